// file: rtl/dcr_consts.svh
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

// Register addresses on the five-bit parallel bus
`define DCR_ADDR_CFG        5'h00
`define DCR_ADDR_GPIO       5'h01
`define DCR_ADDR_PEND       5'h02
`define DCR_BASE_DATA       2'h1
`define DCR_BASE_ZERO       2'h2
`define DCR_BASE_GAIN       2'h3

// Field positions
`define DCR_CFG_CAL_EN_BIT  6
`define DCR_CFG_GBUSY_BIT   5
`define DCR_GPIO_BIT        11
`define DCR_PEND_LSB        4

// Reset values
`define DCR_DATA_RST        12'h000
`define DCR_ZERO_RST        12'h000
`define DCR_GAIN_RST        12'h800
`define DCR_GPIO_RST        1'b1
`define DCR_PEND_RST        8'h00
`define DCR_CODE_MAX        12'hfff

// Gain coefficient is (half scale + code) / 4096
`define DCR_GAIN_HALF       13'h0800
`define DCR_GAIN_SHIFT      12

// Correction time per channel
`define DCR_CLK_PERIOD_NS   25
`define DCR_CORR_NS         500
`define DCR_CORR_CYC \
  ((`DCR_CORR_NS + `DCR_CLK_PERIOD_NS - 1) / `DCR_CLK_PERIOD_NS)

`endif

// file: rtl/dcr_pkg.sv
package dcr_pkg;

  typedef logic [11:0] dcr_code_t;

  // One access on the parallel register bus
  typedef struct packed {
    logic      wr;
    logic      rd;
    logic [4:0] addr;
    dcr_code_t wdata;
  } dcr_req_t;

  typedef enum logic {
    dcr_eng_idle,
    dcr_eng_run
  } dcr_eng_state_t;

endpackage : dcr_pkg

// file: rtl/dcr_corr_math.sv
`timescale 1ns/1ps
`include "dcr_consts.svh"

module dcr_corr_math
  import dcr_pkg::*;
(
  input  wire dcr_code_t code_i,
  input  wire dcr_code_t gain_i,
  input  wire dcr_code_t offset_i,
  output      dcr_code_t result_o
);

  wire [12:0]        coef;
  wire [24:0]        product;
  wire [12:0]        scaled;
  wire signed [14:0] sum;
  wire               under;
  wire               over;

  // Gain 000h is 0.5, FFFh is 1.499756, one step is 1/4096
  assign coef    = `DCR_GAIN_HALF + {1'b0, gain_i};
  assign product = {13'h0000, code_i} * {12'h000, coef};
  assign scaled  = product[24:12];
  // Offset is twos complement, one LSB per step
  assign sum     = $signed({2'b00, scaled})
                 + $signed({{3{offset_i[11]}}, offset_i});
  assign under   = sum[14];
  assign over    = !sum[14] && (sum[13:12] != 2'b00);
  assign result_o = under ? 12'h000 :
                    over  ? `DCR_CODE_MAX : sum[11:0];

endmodule : dcr_corr_math

// file: rtl/dcr_gpio_pad.sv
`timescale 1ns/1ps
`include "dcr_consts.svh"

module dcr_gpio_pad
  import dcr_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic pin_i,
  input  wire logic release_i,
  output      logic pin_oe_o,
  output      logic pin_level_o
);

  logic meta_r;
  logic level_r;
  logic oe_r;

  // Open drain: enable only to pull low, released after reset
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= !release_i;
    end
  end

  // Pin level is asynchronous, two stages before use
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r  <= 1'b1;
      level_r <= 1'b1;
    end else begin
      meta_r  <= pin_i;
      level_r <= meta_r;
    end
  end

  assign pin_oe_o    = oe_r;
  assign pin_level_o = level_r;

endmodule : dcr_gpio_pad

// file: rtl/dcr_cal_regs.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "dcr_consts.svh"

module dcr_cal_regs
  import dcr_pkg::*;
#(
  parameter int NCH      = 8,
  parameter int CORR_CYC = `DCR_CORR_CYC
)
(
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  input  wire dcr_req_t             bus_req_i,
  output      dcr_code_t            bus_rdata_o,
  input  wire logic                 gpio_pin_i,
  output      logic                 gpio_pin_o,
  output      logic                 gpio_pin_oe_o,
  output      logic [NCH-1:0][11:0] conv_data_o,
  output      logic [NCH-1:0]       conv_load_o,
  output      logic                 global_pending_o
);

  //////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [NCH-1:0] chan_hit(
    input logic [4:0] addr,
    input logic [1:0] base,
    input logic       en
  );
    logic [NCH-1:0] hit;
    hit = '0;
    if (en && addr[4:3] == base) begin
      hit[addr[2:0]] = 1'b1;
    end
    return hit;
  endfunction : chan_hit

  function automatic logic [2:0] first_set(input logic [NCH-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  //////////////////////////////////////////////////////////////////////////
  // Storage and state

  localparam logic [4:0] CNT_LOAD = 5'(CORR_CYC - 1);

  dcr_code_t      data_r [NCH];
  dcr_code_t      zero_r [NCH];
  dcr_code_t      gain_r [NCH];
  logic           cal_en_r;
  logic           gpio_bit_r;
  logic           pin_drv_r;
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] pend_nxt;
  logic           gpend_r;
  dcr_code_t      rdata_r;
  logic [NCH-1:0][11:0] conv_r;
  logic [NCH-1:0] load_r;

  dcr_eng_state_t state_r;
  dcr_eng_state_t state_nxt;
  logic [2:0]     sel_r;
  logic [4:0]     cnt_r;

  wire            wr;
  wire [4:0]      addr;
  wire dcr_code_t wdata;
  wire [NCH-1:0]  wr_data;
  wire [NCH-1:0]  wr_zero;
  wire [NCH-1:0]  wr_gain;
  wire [NCH-1:0]  wr_any;
  wire            wr_cfg;
  wire            wr_gpio;
  wire            gpio_bit_nxt;
  wire            rd_mapped;
  wire            done;
  wire [NCH-1:0]  done_mask;
  wire dcr_code_t corr_val;
  wire            pin_level;
  wire dcr_code_t rd_val;
  wire [NCH-1:0]  rd_chan;
  wire            start;

  //////////////////////////////////////////////////////////////////////////
  // Write decode

  assign wr      = bus_req_i.wr;
  assign addr    = bus_req_i.addr;
  assign wdata   = bus_req_i.wdata;
  assign wr_data = chan_hit(addr, `DCR_BASE_DATA, wr);
  assign wr_zero = chan_hit(addr, `DCR_BASE_ZERO, wr);
  assign wr_gain = chan_hit(addr, `DCR_BASE_GAIN, wr);
  assign wr_any  = wr_data | wr_zero | wr_gain;
  assign wr_cfg  = wr && addr == `DCR_ADDR_CFG;
  assign wr_gpio = wr && addr == `DCR_ADDR_GPIO;

  //////////////////////////////////////////////////////////////////////////
  // Per-channel calibration registers

  generate
    for (genvar n = 0; n < NCH; n++) begin : g_chan
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          data_r[n] <= `DCR_DATA_RST;
          zero_r[n] <= `DCR_ZERO_RST;
          gain_r[n] <= `DCR_GAIN_RST;
        end else begin
          if (wr_data[n]) begin
            data_r[n] <= wdata;
          end
          if (wr_zero[n]) begin
            zero_r[n] <= wdata;
          end
          if (wr_gain[n]) begin
            gain_r[n] <= wdata;
          end
        end
      end

      // Converter register: straight path when off, engine result when on
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          conv_r[n] <= `DCR_DATA_RST;
          load_r[n] <= 1'b0;
        end else begin
          load_r[n] <= 1'b0;
          if (!cal_en_r && wr_data[n]) begin
            conv_r[n] <= wdata;
            load_r[n] <= 1'b1;
          end else if (done_mask[n]) begin
            conv_r[n] <= corr_val;
            load_r[n] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Configuration and pin registers

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_en_r   <= 1'b0;
      gpio_bit_r <= `DCR_GPIO_RST;
    end else begin
      if (wr_cfg) begin
        cal_en_r <= wdata[`DCR_CFG_CAL_EN_BIT];
      end
      if (wr_gpio) begin
        gpio_bit_r <= wdata[`DCR_GPIO_BIT];
      end
    end
  end

  // Pad sees the next bit so the pin follows the write edge itself
  assign gpio_bit_nxt = wr_gpio ? wdata[`DCR_GPIO_BIT] : gpio_bit_r;

  dcr_gpio_pad u_gpio (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .pin_i       (gpio_pin_i),
    .release_i   (gpio_bit_nxt),
    .pin_oe_o    (gpio_pin_oe_o),
    .pin_level_o (pin_level)
  );

  // Open drain never drives high; held in a flop like every output
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_drv_r <= 1'b0;
    end else begin
      pin_drv_r <= 1'b0;
    end
  end

  assign gpio_pin_o = pin_drv_r;

  //////////////////////////////////////////////////////////////////////////
  // Correction engine, one channel at a time, lowest index first

  assign start     = cal_en_r && (pend_r != '0);
  assign done      = state_r == dcr_eng_run && cal_en_r && cnt_r == 5'h00;
  assign done_mask = done ? (NCH'(1) << sel_r) : '0;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dcr_eng_idle: begin
        if (start) begin
          state_nxt = dcr_eng_run;
        end
      end
      dcr_eng_run: begin
        if (!cal_en_r || cnt_r == 5'h00) begin
          state_nxt = dcr_eng_idle;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= dcr_eng_idle;
      sel_r   <= 3'h0;
      cnt_r   <= 5'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r == dcr_eng_idle && start) begin
        sel_r <= first_set(pend_r);
        cnt_r <= CNT_LOAD;
      end else if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end

  // Operands are taken at completion so late writes are honoured
  dcr_corr_math u_math (
    .code_i   (data_r[sel_r]),
    .gain_i   (gain_r[sel_r]),
    .offset_i (zero_r[sel_r]),
    .result_o (corr_val)
  );

  //////////////////////////////////////////////////////////////////////////
  // Pending flags: a write in the completion cycle keeps the flag set

  assign pend_nxt = cal_en_r ?
                    ((pend_r & ~done_mask) | wr_any) :
                    '0;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_r  <= `DCR_PEND_RST;
      gpend_r <= 1'b0;
    end else begin
      pend_r  <= pend_nxt;
      gpend_r <= |pend_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path, answer one cycle after the strobe, unmapped reads zero

  assign rd_chan = chan_hit(addr, `DCR_BASE_DATA, 1'b1)
                 | chan_hit(addr, `DCR_BASE_ZERO, 1'b1)
                 | chan_hit(addr, `DCR_BASE_GAIN, 1'b1);

  assign rd_mapped = (rd_chan != '0) || (addr[4:3] == 2'h0);

  assign rd_val =
    (addr == `DCR_ADDR_CFG)  ?
      (12'(cal_en_r) << `DCR_CFG_CAL_EN_BIT) |
      (12'(gpend_r) << `DCR_CFG_GBUSY_BIT) :
    (addr == `DCR_ADDR_GPIO) ?
      (12'(pin_level) << `DCR_GPIO_BIT) :
    (addr == `DCR_ADDR_PEND) ?
      {pend_r, 4'h0} :
    (addr[4:3] == `DCR_BASE_DATA) ? data_r[addr[2:0]] :
    (addr[4:3] == `DCR_BASE_ZERO) ? zero_r[addr[2:0]] :
    (addr[4:3] == `DCR_BASE_GAIN) ? gain_r[addr[2:0]] :
    12'h000;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 12'h000;
    end else if (bus_req_i.rd) begin
      rdata_r <= rd_mapped ? rd_val : 12'h000;
    end
  end

  assign bus_rdata_o      = rdata_r;
  assign conv_data_o      = conv_r;
  assign conv_load_o      = load_r;
  assign global_pending_o = gpend_r;

endmodule : dcr_cal_regs

// file: verif/dcr_cal_regs_properties.sv
`timescale 1ns/1ps
`include "dcr_consts.svh"
module dcr_cal_regs_properties
  import dcr_pkg::*;
#(
  parameter int NCH      = 8,
  parameter int CORR_CYC = 20
)
(
  input wire logic                 core_clk_i,
  input wire logic                 nrst_i,
  input wire dcr_req_t             bus_req_i,
  input wire dcr_code_t            bus_rdata_o,
  input wire logic                 gpio_pin_i,
  input wire logic                 gpio_pin_o,
  input wire logic                 gpio_pin_oe_o,
  input wire logic [NCH-1:0][11:0] conv_data_o,
  input wire logic [NCH-1:0]       conv_load_o,
  input wire logic                 global_pending_o
);
  localparam int LO = CORR_CYC - 1;
  localparam int HI = CORR_CYC + 2;
  logic cal_r;
  wire  wr  = bus_req_i.wr;
  wire  rd  = bus_req_i.rd;
  wire  [4:0] ad = bus_req_i.addr;
  wire  cfg_w = wr && ad == `DCR_ADDR_CFG;
  wire  ch_w  = wr && ad[4:3] != 2'h0;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) cal_r <= 1'b0;
    else if (cfg_w) cal_r <= bus_req_i.wdata[`DCR_CFG_CAL_EN_BIT];
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_PIN_LOW: assert property (gpio_pin_o == 1'b0)
    else $error("pin output not low");
  AST_GPIO_WR: assert property (wr && ad == `DCR_ADDR_GPIO |=>
    gpio_pin_oe_o == !$past(bus_req_i.wdata[11])) else $error("pin enable");
  AST_PEND_SET: assert property (cal_r && ch_w |=> global_pending_o)
    else $error("pending not set");
  AST_OFF_IDLE: assert property (!cal_r |=> !global_pending_o)
    else $error("pending while off");
  AST_BYPASS: assert property (!cal_r && wr && ad[4:3] == `DCR_BASE_DATA |=>
    conv_load_o[$past(bus_req_i.addr[2:0])] &&
    conv_data_o[$past(bus_req_i.addr[2:0])] == $past(bus_req_i.wdata))
    else $error("bypass load");
  AST_CORR_TIME: assert property ($rose(global_pending_o) |->
    ##[LO:HI] (conv_load_o != '0 || !cal_r)) else $error("correction time");
  AST_LOAD_ONE: assert property ($onehot0(conv_load_o))
    else $error("several loads");
  AST_RD_GPIO: assert property (rd && ad == `DCR_ADDR_GPIO |=>
    bus_rdata_o[10:0] == 11'h000) else $error("pin spare bits");
  AST_RD_PEND: assert property (rd && ad == `DCR_ADDR_PEND |=>
    bus_rdata_o[3:0] == 4'h0) else $error("pending low bits");
  AST_RD_CFG: assert property (rd && ad == `DCR_ADDR_CFG |=>
    bus_rdata_o[6] == $past(cal_r)) else $error("enable readback");
  cover property (cal_r && ch_w);
  cover property ($fell(global_pending_o));
  cover property (gpio_pin_oe_o);
endmodule : dcr_cal_regs_properties

bind dcr_cal_regs dcr_cal_regs_properties #(
  .NCH(NCH), .CORR_CYC(CORR_CYC)) u_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req_i),
  .bus_rdata_o(bus_rdata_o), .gpio_pin_i(gpio_pin_i),
  .gpio_pin_o(gpio_pin_o), .gpio_pin_oe_o(gpio_pin_oe_o),
  .conv_data_o(conv_data_o), .conv_load_o(conv_load_o),
  .global_pending_o(global_pending_o));

// file: verif/dcr_pin_model.sv
`timescale 1ns/1ps
module dcr_pin_model (
  input  wire logic pin_oe_i,
  input  wire logic ext_low_i,
  output      logic pin_o
);
  // Pull-up holds the pin high unless a party pulls it low
  assign pin_o = !(pin_oe_i || ext_low_i);
endmodule : dcr_pin_model

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "dcr_consts.svh"
module testbench
  import dcr_pkg::*;
;
  localparam int CC = 12;
  logic             core_clk_i;
  logic             nrst_i;
  logic             pin;
  logic             ext_low;
  logic             pin_o;
  logic             oe;
  logic             gp;
  dcr_req_t         req;
  dcr_code_t        rdata;
  logic [7:0][11:0] cdata;
  logic [7:0]       cload;
  int               fails;
  int               checks_done;
  dcr_cal_regs #(.NCH(8), .CORR_CYC(CC)) dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_req_i(req),
    .bus_rdata_o(rdata), .gpio_pin_i(pin), .gpio_pin_o(pin_o),
    .gpio_pin_oe_o(oe), .conv_data_o(cdata), .conv_load_o(cload),
    .global_pending_o(gp));
  dcr_pin_model pm (.pin_oe_i(oe), .ext_low_i(ext_low), .pin_o(pin));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input dcr_code_t got, input dcr_code_t exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [4:0] a, input dcr_code_t d);
    @(negedge core_clk_i) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk_i) req = '0;
  endtask : wr
  task rd_chk(input logic [4:0] a, input dcr_code_t exp);
    @(negedge core_clk_i) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 12'h000};
    @(negedge core_clk_i) req = '0;
    chk(rdata, exp);
  endtask : rd_chk
  task wait_idle(output int n);
    n = 0;
    while (gp !== 1'b0 && n < 500) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 500) begin
      fails++;
      $display("BAD %0t engine never idle", $time);
    end
  endtask : wait_idle
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd_chk(`DCR_ADDR_GPIO, 12'h800);
    chk({11'h000, oe}, 12'h000);
    rd_chk({`DCR_BASE_GAIN, 3'd4}, 12'h800);
    rd_chk({`DCR_BASE_ZERO, 3'd3}, 12'h000);
    rd_chk(`DCR_ADDR_PEND, 12'h000);
    rd_chk(5'h03, 12'h000);
    $display("test reset done");
  endtask : t_reset
  task t_gpio;
    wr(`DCR_ADDR_GPIO, 12'h7ff);
    chk({11'h000, oe}, 12'h001);
    repeat (3) @(negedge core_clk_i);
    rd_chk(`DCR_ADDR_GPIO, 12'h000);
    wr(`DCR_ADDR_GPIO, 12'h800);
    repeat (3) @(negedge core_clk_i);
    rd_chk(`DCR_ADDR_GPIO, 12'h800);
    ext_low = 1'b1;
    repeat (3) @(negedge core_clk_i);
    rd_chk(`DCR_ADDR_GPIO, 12'h000);
    ext_low = 1'b0;
    $display("test gpio done");
  endtask : t_gpio
  task t_bypass;
    wr({`DCR_BASE_DATA, 3'd1}, 12'habc);
    chk(cdata[1], 12'habc);
    chk({4'h0, cload}, 12'h002);
    rd_chk({`DCR_BASE_DATA, 3'd1}, 12'habc);
    chk({11'h000, gp}, 12'h000);
    $display("test bypass done");
  endtask : t_bypass
  task t_corr;
    dcr_code_t tab [4][4] = '{'{12'hfff, 12'h001, 12'h400, 12'h600},
                              '{12'hfff, 12'h7ff, 12'hfff, 12'hfff},
                              '{12'h800, 12'h800, 12'h010, 12'h000},
                              '{12'h000, 12'hfff, 12'h800, 12'h3ff}};
    int n;
    wr(`DCR_ADDR_CFG, 12'h040);
    for (int i = 0; i < 4; i++) begin
      wr({`DCR_BASE_GAIN, 3'd2}, tab[i][0]);
      wr({`DCR_BASE_ZERO, 3'd2}, tab[i][1]);
      wr({`DCR_BASE_DATA, 3'd2}, tab[i][2]);
      rd_chk(`DCR_ADDR_CFG, 12'h060);
      rd_chk(`DCR_ADDR_PEND, 12'h040);
      wait_idle(n);
      chk(cdata[2], tab[i][3]);
    end
    rd_chk(`DCR_ADDR_PEND, 12'h000);
    $display("test correction done");
  endtask : t_corr
  task t_multi;
    int n;
    wr({`DCR_BASE_DATA, 3'd0}, 12'h123);
    wr({`DCR_BASE_DATA, 3'd7}, 12'h456);
    rd_chk(`DCR_ADDR_PEND, 12'h810);
    wait_idle(n);
    chk({11'h000, n >= CC && n <= 2 * CC + 2}, 12'h001);
    chk(cdata[0], 12'h123);
    chk(cdata[7], 12'h456);
    $display("test two channels done");
  endtask : t_multi
  task t_off;
    wr({`DCR_BASE_ZERO, 3'd5}, 12'h001);
    wr(`DCR_ADDR_CFG, 12'h000);
    repeat (2) @(negedge core_clk_i);
    chk({11'h000, gp}, 12'h000);
    rd_chk(`DCR_ADDR_PEND, 12'h000);
    chk(cdata[5], 12'h000);
    $display("test disable done");
  endtask : t_off
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    #(5000 * 25);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict;
  end
  initial begin
    req = '0;
    ext_low = 1'b0;
    nrst_i = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (2) @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_reset;
    t_gpio;
    t_bypass;
    t_corr;
    t_multi;
    t_off;
    print_verdict;
  end
endmodule : testbench
